/* File: cmbi_pkg.sv */
// cmbi_pkg: constants, op codes, states and carriers of the memory bus interface.
// assumes a single 125 MHz core clock; all pin timing is derived from it.
package cmbi_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // least times, rounded up to whole clock cycles
  localparam int CACHE_RD_NS = 24;
  localparam int CACHE_RD_CYC = (CACHE_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CACHE_WR_NS = 16;
  localparam int CACHE_WR_CYC = (CACHE_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ASYNC_MIN_NS = 32;
  localparam int ASYNC_MIN_CYC = (ASYNC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int TAG_W = 19;
  localparam int TAG_LSB = 13;
  localparam int ADDR_LO_W = 24;
  localparam int COND_W = 4;
  localparam int IRQ_W = 6;
  localparam int SIZE_W = 2;
  // mode bit, sampled from the interrupt pins at reset, that turns parity on
  localparam int MODE_PAR_BIT = 0;
  localparam logic [IRQ_W-1:0] MODE_RST = 6'h00;
  localparam logic [2:0] KIND_IDLE = 3'h0;

  typedef enum logic [2:0] {
    OP_IRD = 3'h0,
    OP_IWR = 3'h1,
    OP_DRD = 3'h2,
    OP_DWR = 3'h3,
    OP_ARD = 3'h4,
    OP_AWR = 3'h5
  } cmbi_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CRD = 3'h1,
    ST_CWR = 3'h2,
    ST_ARD = 3'h3,
    ST_AWR = 3'h4,
    ST_CPST = 3'h5,
    ST_DMA = 3'h6
  } cmbi_state_t;

  typedef struct packed {
    cmbi_op_t op;
    logic fetch;
    logic [SIZE_W-1:0] size;
    logic [31:0] addr;
    logic [DATA_W-1:0] wdata;
  } cmbi_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic hit;
    logic parity_bad;
    logic bus_fault;
    logic burst;
  } cmbi_rsp_t;

  // even parity: each bit makes its byte plus itself hold an even count of ones
  function automatic logic [PAR_W-1:0] cmbi_par(input logic [DATA_W-1:0] d);
    logic [PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < PAR_W; i++) begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction
endpackage

/* File: cmbi_sync.sv */
// cmbi_sync: two-flop synchroniser for a vector of unrelated levels.
// assumes each bit is a slow level; no bus coherence is promised across bits.
`timescale 1ns/100ps
`default_nettype none
module cmbi_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic ref_clk,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  if (W < 1) begin : g_chk
    $error("cmbi_sync width must be at least 1");
  end

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule
`default_nettype wire

/* File: cmbi_top.sv */
// cmbi_top: cache sram and asynchronous memory interface of the processor.
// assumes pin inputs are asynchronous to ref_clk and that the core holds req until taken.
`timescale 1ns/100ps
`default_nettype none
// Function
// - one shared 32-bit data bus for everything
// - drive even byte parity on every write
// - bad parity when enabled: flag and miss
// - 19-bit tag bus carries tags, high address
// - 24-bit low address bus for all spaces
// - cache enables have selectable active polarity
// - cache latch clocks toggle all the time
// - valid high means tags valid; written on update
// - sticky parity fault until software clears it
// - top kind pin function chosen at reset
// - 3-bit kind bus: size, data, purpose
// - strobe each async read and write cycle
// - enable read buffer during async reads
// - run output shows run versus stall
// - exception output aborts committing instruction
// - read stall held; sampled only in read stalls
// - write stall sampled only during writes
// - coprocessor stall input starts and ends stalls
// - condition bit 0 picks burst refill
// - dma hold stalls and floats cache interface
// - interrupt pins sampled as modes at reset
module cmbi_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // core request and answer
  input wire logic req_valid,
  input wire cmbi_pkg::cmbi_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output cmbi_pkg::cmbi_rsp_t rsp,
  input wire logic exception_req,
  // configuration and status
  input wire logic [3:0] strobe_pol,
  input wire logic parity_fault_clear,
  output logic parity_fault_flag,
  output logic parity_enabled,
  output logic [cmbi_pkg::IRQ_W-1:0] mode_bits,
  output logic [cmbi_pkg::IRQ_W-1:0] irq_level,
  output logic [cmbi_pkg::COND_W-2:0] coproc_branch_cond,
  // shared data, parity, tag and valid pins
  input wire logic [cmbi_pkg::DATA_W-1:0] data_in,
  output logic [cmbi_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [cmbi_pkg::PAR_W-1:0] byte_parity_bus_in,
  output logic [cmbi_pkg::PAR_W-1:0] byte_parity_bus_out,
  output logic byte_parity_bus_oe,
  input wire logic [cmbi_pkg::TAG_W-1:0] tag_in,
  output logic [cmbi_pkg::TAG_W-1:0] tag_out,
  output logic tag_oe,
  input wire logic valid_in,
  output logic valid_out,
  output logic valid_oe,
  // cache control pins
  output logic [cmbi_pkg::ADDR_LO_W-1:0] low_address_bus,
  output logic cache_ctrl_oe,
  output logic icache_output_enable,
  output logic icache_write_enable,
  output logic dcache_output_enable,
  output logic dcache_write_enable,
  output logic icache_latch_clock,
  output logic dcache_latch_clock,
  // asynchronous memory pins
  output logic [1:0] access_kind_bus,
  output logic access_kind_top_pin,
  output logic async_read_strobe,
  output logic async_write_strobe,
  output logic read_buffer_enable,
  input wire logic bus_fault_in,
  input wire logic read_stall_in,
  input wire logic write_stall_in,
  // processor control pins
  output logic run,
  output logic exception,
  output logic system_clock_out,
  output logic coproc_sync_clock,
  input wire logic coproc_stall_in,
  input wire logic [cmbi_pkg::COND_W-1:0] coproc_condition_bus,
  input wire logic dma_hold_in,
  input wire logic [cmbi_pkg::IRQ_W-1:0] irq_in,
  input wire logic double_rate_master_clock
);
  import cmbi_pkg::*;

  localparam int BUS_W = DATA_W + PAR_W + TAG_W + 1;
  localparam int CTL_W = COND_W + IRQ_W + 6;

  logic [DATA_W-1:0] d_s;
  logic [PAR_W-1:0] p_s;
  logic [TAG_W-1:0] t_s;
  logic v_s, rs_s, ws_s, cs_s, dma_s, bf_s, mclk_s, mclk_d_r;
  logic [COND_W-1:0] cc_s;
  logic [IRQ_W-1:0] irq_s;
  cmbi_state_t state_r, state_nxt;
  cmbi_req_t cur_r, cur_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic take, last, mclk_rise, par_en, par_bad, par_set, hit_nxt;
  logic div_r, flag_r;
  logic [2:0] kind_nxt;
  // every pin input crosses two flops before use
  cmbi_sync #(.W(BUS_W)) u_sync_bus (
    .ref_clk(ref_clk),
    .d({data_in, byte_parity_bus_in, tag_in, valid_in}),
    .q({d_s, p_s, t_s, v_s})
  );
  cmbi_sync #(.W(CTL_W)) u_sync_ctl (
    .ref_clk(ref_clk),
    .d({coproc_condition_bus, irq_in, read_stall_in, write_stall_in, coproc_stall_in,
        dma_hold_in, bus_fault_in, double_rate_master_clock}),
    .q({cc_s, irq_s, rs_s, ws_s, cs_s, dma_s, bf_s, mclk_s})
  );
  assign par_en = mode_bits[MODE_PAR_BIT];
  assign mclk_rise = mclk_s & ~mclk_d_r;
  assign take = (state_r == ST_IDLE) && req_valid && req_ready;
  // sequencing of cache, async and stall states
  always_comb begin
    state_nxt = state_r;
    last = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          case (req.op)
            OP_IRD, OP_DRD: state_nxt = ST_CRD;
            OP_IWR, OP_DWR: state_nxt = ST_CWR;
            OP_ARD: state_nxt = ST_ARD;
            OP_AWR: state_nxt = ST_AWR;
            default: state_nxt = ST_IDLE;
          endcase
        end else if (dma_s) begin
          state_nxt = ST_DMA;
        end else if (cs_s) begin
          state_nxt = ST_CPST;
        end
      end
      ST_CRD: last = (cnt_r == CNT_W'(CACHE_RD_CYC - 1));
      ST_CWR: last = (cnt_r == CNT_W'(CACHE_WR_CYC - 1));
      // read stall ends when the memory drops it or signals a bus fault
      ST_ARD: last = (cnt_r >= CNT_W'(ASYNC_MIN_CYC - 1)) && (!rs_s || bf_s);
      ST_AWR: last = (cnt_r >= CNT_W'(ASYNC_MIN_CYC - 1)) && (!ws_s || bf_s);
      ST_CPST: last = !cs_s;
      ST_DMA: last = !dma_s;
      default: last = 1'b1;
    endcase
    if (last) begin
      state_nxt = ST_IDLE;
    end
  end
  always_comb begin
    cur_nxt = take ? req : cur_r;
    par_bad = par_en && (p_s != cmbi_par(d_s));
    hit_nxt = v_s && (t_s == cur_r.addr[31:TAG_LSB]) && !par_bad;
    par_set = (state_r == ST_CRD) && last && par_bad;
    kind_nxt = KIND_IDLE;
    if (state_nxt == ST_ARD || state_nxt == ST_AWR) begin
      kind_nxt = {~cur_nxt.fetch, cur_nxt.size};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cur_r <= '0;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      if (state_nxt != state_r) begin
        cnt_r <= '0;
      end else if (cnt_r != '1) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
  // modes caught while reset is held, not re-latched until the next reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_bits <= irq_s;
      irq_level <= '0;
    end else begin
      irq_level <= irq_s;
    end
  end
  // sticky fault; a new error beats a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (par_set) begin
      flag_r <= 1'b1;
    end else if (parity_fault_clear) begin
      flag_r <= 1'b0;
    end
  end
  assign parity_fault_flag = flag_r;
  assign parity_enabled = par_en;
  // latch clocks free-run, toggling on each master clock rising edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mclk_d_r <= 1'b0;
      div_r <= 1'b0;
    end else begin
      mclk_d_r <= mclk_s;
      if (mclk_rise) begin
        div_r <= ~div_r;
      end
    end
  end
  assign icache_latch_clock = div_r;
  assign dcache_latch_clock = div_r;
  assign system_clock_out = div_r;
  assign coproc_sync_clock = div_r;
  // answers to the core
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
      exception <= 1'b0;
      coproc_branch_cond <= '0;
    end else begin
      req_ready <= (state_nxt == ST_IDLE) && !dma_s && !cs_s;
      rsp_valid <= last && (state_r inside {ST_CRD, ST_CWR, ST_ARD, ST_AWR});
      coproc_branch_cond <= cc_s[COND_W-1:1];
      exception <= exception_req || (last && bf_s && (state_r inside {ST_ARD, ST_AWR}));
      if (last) begin
        rsp.rdata <= d_s;
        rsp.hit <= (state_r == ST_CRD) && hit_nxt;
        rsp.parity_bad <= (state_r == ST_CRD) && par_bad;
        rsp.bus_fault <= (state_r inside {ST_ARD, ST_AWR}) && bf_s;
        rsp.burst <= (state_r == ST_CRD) && !hit_nxt && cc_s[0];
      end
    end
  end
  // pin drive, registered from the next state so pins switch with the state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_out <= '0;
      data_oe <= 1'b0;
      byte_parity_bus_out <= '0;
      byte_parity_bus_oe <= 1'b0;
      tag_out <= '0;
      tag_oe <= 1'b0;
      valid_out <= 1'b0;
      valid_oe <= 1'b0;
      low_address_bus <= '0;
      cache_ctrl_oe <= 1'b0;
    end else begin
      data_out <= cur_nxt.wdata;
      data_oe <= state_nxt inside {ST_CWR, ST_AWR};
      byte_parity_bus_out <= cmbi_par(cur_nxt.wdata);
      byte_parity_bus_oe <= state_nxt inside {ST_CWR, ST_AWR};
      tag_out <= cur_nxt.addr[31:TAG_LSB];
      tag_oe <= state_nxt inside {ST_CWR, ST_ARD, ST_AWR};
      valid_out <= 1'b1;
      valid_oe <= state_nxt == ST_CWR;
      low_address_bus <= cur_nxt.addr[ADDR_LO_W-1:0];
      // floated while dma owns the sram buses
      cache_ctrl_oe <= state_nxt != ST_DMA;
    end
  end
  // polarity bit high means the strobe is active high
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      icache_output_enable <= 1'b0;
      icache_write_enable <= 1'b0;
      dcache_output_enable <= 1'b0;
      dcache_write_enable <= 1'b0;
    end else begin
      icache_output_enable <= ~(((state_nxt == ST_CRD) && cur_nxt.op == OP_IRD) ^ strobe_pol[0]);
      icache_write_enable <= ~(((state_nxt == ST_CWR) && cur_nxt.op == OP_IWR) ^ strobe_pol[1]);
      dcache_output_enable <= ~(((state_nxt == ST_CRD) && cur_nxt.op == OP_DRD) ^ strobe_pol[2]);
      dcache_write_enable <= ~(((state_nxt == ST_CWR) && cur_nxt.op == OP_DWR) ^ strobe_pol[3]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      access_kind_bus <= '0;
      access_kind_top_pin <= 1'b0;
      async_read_strobe <= 1'b0;
      async_write_strobe <= 1'b0;
      read_buffer_enable <= 1'b0;
      run <= 1'b0;
    end else begin
      access_kind_bus <= kind_nxt[1:0];
      // shared pin: low-active fault output when parity is on
      access_kind_top_pin <= par_en ? ~(flag_r | par_set) : kind_nxt[2];
      async_read_strobe <= state_nxt == ST_ARD;
      async_write_strobe <= state_nxt == ST_AWR;
      read_buffer_enable <= state_nxt == ST_ARD;
      run <= state_nxt inside {ST_IDLE, ST_CRD, ST_CWR};
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  par_gen_a: assert property (data_oe |-> byte_parity_bus_out == cmbi_par(data_out))
    else $error("write parity not even");
  par_miss_a: assert property (par_set |=> rsp_valid && rsp.parity_bad && !rsp.hit)
    else $error("parity error not reported as miss");
  tag_drive_a: assert property (tag_oe |-> tag_out == cur_r.addr[31:TAG_LSB])
    else $error("tag bus not high address");
  pol_idle_a: assert property (state_r == ST_IDLE && !$past(rst)
      |-> icache_output_enable == ~$past(strobe_pol[0]))
    else $error("idle icache enable not inactive");
  latch_clk_a: assert property (mclk_rise |=> icache_latch_clock != $past(icache_latch_clock))
    else $error("latch clock missed a toggle");
  flag_hold_a: assert property (flag_r && !parity_fault_clear |=> flag_r)
    else $error("parity fault flag lost");
  top_pin_a: assert property (par_en && par_set |=> !access_kind_top_pin [*2])
    else $error("fault pin not low after error");
  rd_strobe_a: assert property (state_r == ST_ARD |-> async_read_strobe && read_buffer_enable)
    else $error("async read strobes missing");
  rd_wait_a: assert property (state_r == ST_ARD && rs_s && !bf_s |=> state_r == ST_ARD)
    else $error("read stall ended while busy");
  wr_wait_a: assert property (state_r == ST_AWR && ws_s && !bf_s |=> state_r == ST_AWR)
    else $error("write stall ended while busy");
  cp_run_a: assert property (state_r == ST_CPST |-> !run)
    else $error("run high in coprocessor stall");
  dma_float_a: assert property (state_r == ST_DMA |-> !cache_ctrl_oe && !data_oe && !tag_oe)
    else $error("cache interface driven in dma");
  crd_len_a: assert property ($rose(state_r == ST_CRD) |-> ##[1:3] rsp_valid)
    else $error("cache read took too long");

  cov_hit_c: cover property (rsp_valid && rsp.hit);
  cov_ard_c: cover property (state_r == ST_ARD ##1 state_r == ST_IDLE);
  cov_dma_c: cover property (state_r == ST_DMA ##1 state_r == ST_IDLE);
  cov_par_c: cover property (par_set);
endmodule
`default_nettype wire

/* File: cmbi_mem_model.sv */
// cmbi_mem_model: cache srams and async memory on the far side of the pins.
// assumes the bench steers word, tag, stall length and faults.
`timescale 1ns/100ps
`default_nettype none
module cmbi_mem_model (
  // clock and device pins
  input wire logic ref_clk,
  input wire logic [3:0] strobe_pol,
  input wire logic ioe,
  input wire logic doe,
  input wire logic rbe,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [31:0] dout,
  input wire logic d_oe,
  input wire logic [3:0] pout,
  input wire logic [18:0] tout,
  input wire logic t_oe,
  output logic [31:0] din,
  output logic [3:0] par_in,
  output logic [18:0] tin,
  output logic valid,
  output logic rd_stall,
  output logic wr_stall,
  output logic fault_out,
  // bench controls
  input wire logic [31:0] word,
  input wire logic [18:0] tag,
  input wire logic bad_par,
  input wire logic fault,
  input wire logic [3:0] wait_cyc
);
  logic [3:0] cnt_r = 4'h0;
  logic [31:0] last_r = 32'h0;
  logic [3:0] par_w;
  logic drv;
  always_comb begin
    for (int i = 0; i < 4; i++) par_w[i] = ^word[8*i +: 8];
    par_w[0] = par_w[0] ^ bad_par;
  end
  assign drv = (ioe == strobe_pol[0]) || (doe == strobe_pol[2]) || rbe;
  always @(posedge ref_clk) begin
    cnt_r <= (rd_stb || wr_stb) ? ((cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1) : 4'h0;
    last_r <= din;
  end
  // a released data bus flips each cycle so a stale copy never passes; released parity and tag show the inverse
  assign din = d_oe ? dout : (drv ? word : ~last_r);
  assign par_in = d_oe ? pout : (drv ? par_w : ~par_w);
  assign tin = t_oe ? tout : (drv ? tag : ~tag);
  assign valid = drv;
  assign rd_stall = !(rd_stb && cnt_r >= wait_cyc);
  assign wr_stall = wr_stb && cnt_r < wait_cyc;
  assign fault_out = fault && (rd_stb || wr_stb);
endmodule
`default_nettype wire

/* File: cmbi_top_tb.sv */
// cmbi_top_tb: self-checking bench of the memory bus interface.
// assumes cmbi_mem_model answers for srams and async memory.
`timescale 1ns/100ps
`default_nettype none
module cmbi_top_tb;
  import cmbi_pkg::*;
  logic ref_clk, rst, req_valid, req_ready, rsp_valid, exception_req, exception, run;
  logic parity_fault_clear, parity_fault_flag, parity_enabled, data_oe, byte_parity_bus_oe;
  logic tag_oe, valid_in, valid_out, valid_oe, cache_ctrl_oe, access_kind_top_pin;
  logic icache_output_enable, icache_write_enable, dcache_output_enable, dcache_write_enable;
  logic icache_latch_clock, dcache_latch_clock, system_clock_out, coproc_sync_clock;
  logic async_read_strobe, async_write_strobe, read_buffer_enable, bus_fault_in;
  logic read_stall_in, write_stall_in, coproc_stall_in, dma_hold_in, double_rate_master_clock;
  logic bad_par, fault, s_rd, s_rbe, s_wr, s_exc, s_run0, s_we, s_vo;
  logic [3:0] strobe_pol, byte_parity_bus_in, byte_parity_bus_out, coproc_condition_bus;
  logic [3:0] wait_cyc, s_par;
  logic [5:0] mode_bits, irq_level, irq_in;
  logic [2:0] coproc_branch_cond;
  logic [1:0] access_kind_bus;
  logic [2:0] s_kind;
  logic [31:0] data_in, data_out, word, s_data;
  logic [18:0] tag_in, tag_out, tag, s_tag;
  logic [23:0] low_address_bus;
  cmbi_req_t req;
  cmbi_rsp_t rsp;
  int error_cnt, total_checks, lat;

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    double_rate_master_clock = 1'b0;
    #3;
    forever #32 double_rate_master_clock = ~double_rate_master_clock;
  end

  cmbi_top dut_u (.*);
  cmbi_mem_model model_u (.ref_clk(ref_clk), .strobe_pol(strobe_pol),
    .ioe(icache_output_enable), .doe(dcache_output_enable), .rbe(read_buffer_enable),
    .rd_stb(async_read_strobe), .wr_stb(async_write_strobe), .dout(data_out),
    .d_oe(data_oe), .pout(byte_parity_bus_out), .tout(tag_out), .t_oe(tag_oe),
    .din(data_in), .par_in(byte_parity_bus_in), .tin(tag_in), .valid(valid_in),
    .rd_stall(read_stall_in), .wr_stall(write_stall_in), .fault_out(bus_fault_in),
    .word(word), .tag(tag), .bad_par(bad_par), .fault(fault), .wait_cyc(wait_cyc));

  task automatic stop_test();
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic hang(input string msg);
    error_cnt++;
    $display("CHECK FAILED %0t %s timed out", $time, msg);
    stop_test();
  endtask

  function automatic logic [3:0] epar(input logic [31:0] w);
    for (int i = 0; i < 4; i++) epar[i] = ^w[8*i +: 8];
  endfunction

  // one access; records what the pins showed until the answer
  task automatic access(input cmbi_op_t op, input logic [31:0] a, input logic [31:0] wd,
      input logic [1:0] sz);
    @(negedge ref_clk);
    req = '{op: op, fetch: 1'b0, size: sz, addr: a, wdata: wd};
    req_valid = 1'b1;
    lat = 0;
    while (req_ready !== 1'b1) begin
      @(negedge ref_clk);
      if (++lat > 50) hang("take");
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
    {s_rd, s_rbe, s_wr, s_exc, s_run0, s_we, s_vo} = 7'h00;
    lat = 1;
    forever begin
      s_rd |= async_read_strobe;
      s_rbe |= read_buffer_enable;
      s_wr |= async_write_strobe;
      s_exc |= exception;
      s_run0 |= !run;
      s_we |= (dcache_write_enable === strobe_pol[3]);
      if (async_read_strobe) s_kind = {access_kind_top_pin, access_kind_bus};
      if (data_oe) begin
        s_data = data_out;
        s_par = byte_parity_bus_out;
        s_tag = tag_out;
        s_vo = valid_oe & valid_out;
      end
      if (rsp_valid === 1'b1) break;
      @(negedge ref_clk);
      if (++lat > 60) hang("answer");
    end
  endtask

  task automatic t_modes();
    chk(parity_enabled, 1, "parity mode");
    chk(mode_bits, 6'h01, "modes kept");
    chk(irq_level, 6'h2a, "irq follow");
    chk({dcache_write_enable, dcache_output_enable, icache_write_enable,
      icache_output_enable}, 4'ha, "idle pol");
    strobe_pol = 4'ha;
    repeat (2) @(negedge ref_clk);
    chk({dcache_write_enable, dcache_output_enable, icache_write_enable,
      icache_output_enable}, 4'h5, "idle pol inv");
  endtask

  task automatic t_clocks();
    int n;
    logic prev;
    n = 0;
    prev = icache_latch_clock;
    repeat (80) begin
      @(negedge ref_clk);
      n += (icache_latch_clock !== prev);
      prev = icache_latch_clock;
      chk(dcache_latch_clock, icache_latch_clock, "dcache_latch_clock");
    end
    chk(n >= 9 && n <= 11, 1, "latch toggles");
  endtask

  task automatic t_cache();
    cmbi_op_t wops[2] = '{OP_IWR, OP_DWR};
    cmbi_op_t rops[2] = '{OP_IRD, OP_DRD};
    for (int i = 0; i < 2; i++) begin
      access(wops[i], 32'h8143_a5c3 + i, 32'hc3a5_0f71 ^ i, 2'h3);
      chk(s_data, 32'hc3a5_0f71 ^ i, "wr data");
      chk(s_par, epar(32'hc3a5_0f71 ^ i), "wr parity");
      chk(s_tag, 19'h40a1d, "wr tag");
      chk(low_address_bus, 24'h43_a5c3 + i, "low addr");
      chk(s_vo, 1, "valid bit");
    end
    chk(s_we, 1, "dwe active");
    tag = 19'h40a1d;
    for (int i = 0; i < 2; i++) begin
      word = 32'h5a01_7e80 + i;
      access(rops[i], 32'h8143_a5c0, 32'h0, 2'h3);
      chk(rsp.rdata, 32'h5a01_7e80 + i, "rd data");
      chk({rsp.hit, rsp.parity_bad}, 2'h2, "rd hit");
    end
    bad_par = 1'b1;
    access(OP_DRD, 32'h8143_a5c0, 32'h0, 2'h3);
    bad_par = 1'b0;
    chk({rsp.hit, rsp.parity_bad}, 2'h1, "bad parity miss");
    access(OP_IRD, 32'h8143_a5c0, 32'h0, 2'h3);
    chk(parity_fault_flag, 1, "sticky");
    chk(access_kind_top_pin, 0, "fault pin");
    parity_fault_clear = 1'b1;
    @(negedge ref_clk);
    parity_fault_clear = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({parity_fault_flag, access_kind_top_pin}, 2'h1, "cleared");
  endtask

  task automatic t_async();
    wait_cyc = 4'ha;
    word = 32'h9e37_0c15;
    access(OP_ARD, 32'h1fc0_0100, 32'h0, 2'h1);
    chk(rsp.rdata, 32'h9e37_0c15, "async rd");
    chk({s_rd, s_rbe, s_run0}, 3'h7, "rd strobes");
    chk(s_kind[1:0], 2'h1, "kind size");
    chk(lat > 10, 1, "rd stall held");
    wait_cyc = 4'h8;
    access(OP_AWR, 32'h1fc0_0204, 32'h6b2d_f003, 2'h2);
    chk(s_wr, 1, "wr strobe");
    chk(s_data, 32'h6b2d_f003, "async wr data");
    chk(s_par, epar(32'h6b2d_f003), "async wr par");
    chk(s_tag, 19'h0fe00, "async tag");
    chk(lat > 8, 1, "wr stall held");
    wait_cyc = 4'he;
    fault = 1'b1;
    access(OP_ARD, 32'h1fc0_0300, 32'h0, 2'h2);
    fault = 1'b0;
    repeat (3) begin
      @(negedge ref_clk);
      s_exc |= exception;
    end
    chk({rsp.bus_fault, s_exc}, 2'h3, "bus fault");
    s_exc = 1'b0;
    exception_req = 1'b1;
    repeat (3) begin
      @(negedge ref_clk);
      exception_req = 1'b0;
      s_exc |= exception;
    end
    chk(s_exc, 1, "exception pulse");
  endtask

  task automatic t_stall(input logic dma);
    int n;
    @(negedge ref_clk);
    dma_hold_in = dma;
    coproc_stall_in = !dma;
    coproc_condition_bus = 4'hb;
    repeat (6) @(negedge ref_clk);
    chk({req_ready, run}, 2'h0, "stalled");
    chk(cache_ctrl_oe, !dma, "float");
    chk(coproc_branch_cond, 3'h5, "branch cond");
    dma_hold_in = 1'b0;
    coproc_stall_in = 1'b0;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(negedge ref_clk);
      if (++n > 20) hang("stall end");
    end
    chk({run, cache_ctrl_oe}, 2'h3, "resumed");
  endtask

  // second reset with parity off: top kind pin carries the data bit
  task automatic t_nopar();
    @(negedge ref_clk);
    rst = 1'b1;
    irq_in = 6'h00;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk({parity_enabled, mode_bits}, 7'h00, "modes off");
    access(OP_ARD, 32'h1fc0_0400, 32'h0, 2'h2);
    chk(s_kind, 3'h6, "kind data bit");
    bad_par = 1'b1;
    access(OP_DRD, 32'h8143_a5c0, 32'h0, 2'h3);
    bad_par = 1'b0;
    chk({parity_fault_flag, rsp.hit, rsp.parity_bad}, 3'h2, "parity off");
  endtask

  initial begin
    {rst, req_valid, exception_req, parity_fault_clear, coproc_stall_in, dma_hold_in} = 6'h20;
    {bad_par, fault} = 2'h0;
    req = '0;
    strobe_pol = 4'h5;
    irq_in = 6'h01;
    coproc_condition_bus = 4'h0;
    word = 32'h0;
    tag = 19'h0;
    wait_cyc = 4'h3;
    error_cnt = 0;
    total_checks = 0;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    irq_in = 6'h2a;
    repeat (6) @(negedge ref_clk);
    t_modes();
    t_clocks();
    t_cache();
    t_async();
    t_stall(1'b1);
    t_stall(1'b0);
    t_nopar();
    stop_test();
  end
endmodule
`default_nettype wire
